// file: rtl/fsp_params.svh
// Constants for the five-stage integer pipeline control.
// Assumes includers use the fsp_pkg types; definitions only.
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
`define FSP_OP_MSB        31
`define FSP_OP_LSB        26
`define FSP_RS_LSB        21
`define FSP_RT_LSB        16
`define FSP_RD_LSB        11
`define FSP_RESET_PC      32'h0000_0000
`define FSP_PHYS_MASK     32'h1FFF_FFFF
`define FSP_MUL_HOLD      6'd31
`define FSP_MAC_HOLD      6'd33
`define FSP_DIV_HOLD      6'd32
`define FSP_DIV_NEG_DIVSR 6'd1
`define FSP_DIV_NEG_DIVND 6'd2
`endif

// file: rtl/fsp_pkg.sv
// Types for the five-stage integer pipeline control.
// Assumes fsp_params.svh supplies the numeric constants.
package fsp_pkg;
  typedef enum logic [5:0] {
    FSP_NOP   = 6'h00, FSP_ADD   = 6'h01, FSP_SUB  = 6'h02, FSP_AND  = 6'h03,
    FSP_OR    = 6'h04, FSP_ADDI  = 6'h05, FSP_LW   = 6'h06, FSP_LBU  = 6'h07,
    FSP_SW    = 6'h08, FSP_BEQ   = 6'h09, FSP_BNE  = 6'h0A, FSP_MULT = 6'h0B,
    FSP_MULTU = 6'h0C, FSP_MULTIPLY_ADD_OP  = 6'h0D, FSP_MULTIPLY_SUBTRACT_OP = 6'h0E, FSP_MUL3 = 6'h0F,
    FSP_DIV   = 6'h10, FSP_DIVU  = 6'h11, FSP_MFHI = 6'h12, FSP_MFLO = 6'h13,
    FSP_WAIT  = 6'h14
  } fsp_op_t;

  typedef enum logic {FSP_RUN = 1'b0, FSP_SLEEP = 1'b1} fsp_pwr_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] ir;
    logic [31:0] pc;
  } fsp_e_t;

  typedef struct packed {
    logic        valid;
    fsp_op_t     op;
    logic [4:0]  rd;
    logic        wen;
    logic        load;
    logic        mem;
    logic        store;
    logic        multiply_divide_unit;
    logic [5:0]  cnt;
    logic [31:0] res;
    logic [31:0] paddr;
    logic [31:0] opa;
    logic [31:0] opb;
  } fsp_m_t;

  typedef struct packed {
    logic        valid;
    fsp_op_t     op;
    logic [4:0]  rd;
    logic        wen;
    logic        lbu;
    logic [1:0]  bsel;
    logic        multiply_divide_unit;
    logic [31:0] res;
    logic [63:0] prod;
  } fsp_a_t;

  typedef struct packed {
    logic        wen;
    logic [4:0]  rd;
    logic [31:0] res;
  } fsp_w_t;

  typedef struct packed {
    logic [31:0]       pc;
    fsp_pwr_t          pwr;
    logic              ireq;
    fsp_e_t            e;
    fsp_m_t            m;
    fsp_a_t            a;
    fsp_w_t            w;
    logic [31:0]       hi;
    logic [31:0]       lo;
    logic [31:0][31:0] rf;
  } fsp_state_t;
endpackage

// file: rtl/fsp_pipe.sv
// Five-stage integer pipeline: fetch, execute, memory, align, writeback.
// Assumes caches answer with an ack in the cycle the critical word is valid.
`timescale 1ns/1ps
`include "fsp_params.svh"

module fsp_pipe
  import fsp_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic [31:0] icache_data_in,
  input  wire logic        icache_ack_in,
  input  wire logic [31:0] dcache_rdata_in,
  input  wire logic        dcache_ack_in,
  input  wire logic        wake_in,
  output logic             icache_req_out,
  output logic [31:0]      icache_addr_out,
  output logic             dcache_req_out,
  output logic             dcache_we_out,
  output logic [31:0]      dcache_addr_out,
  output logic [31:0]      dcache_wdata_out,
  output logic             sleep_out
);

  fsp_state_t         st_q;
  fsp_state_t         st_d;
  fsp_op_t            op_e;
  logic [4:0]         rs_e;
  logic [4:0]         rt_e;
  logic [4:0]         rd_e;
  logic [31:0]        imm_e;
  logic [31:0]        a_e;
  logic [31:0]        b_e;
  logic [31:0]        a_val;
  logic [31:0]        alu_e;
  logic [31:0]        tgt_e;
  logic               br_take;
  logic               uses_rt;
  logic               mdu_e;
  logic               hold_m;
  logic               hazard_e;
  logic               fetch_ok;
  logic               stall_e;
  logic signed [63:0] prod_s;
  logic        [63:0] prod_u;
  logic        [63:0] mdu_res;

  function automatic logic [31:0] fwd(input logic [4:0] idx);
    logic [31:0] v;
    v = st_q.rf[idx];
    if (st_q.w.wen && st_q.w.rd == idx) begin
      v = st_q.w.res;
    end
    if (st_q.a.valid && st_q.a.wen && st_q.a.rd == idx) begin
      v = a_val;
    end
    if (st_q.m.valid && st_q.m.wen && !st_q.m.load && st_q.m.rd == idx) begin
      v = st_q.m.res;
    end
    if (idx == 5'd0) begin
      v = 32'h0000_0000;
    end
    return v;
  endfunction

  function automatic logic dep(input logic [4:0] idx, input logic use_rt);
    return (idx != 5'd0) && (idx == rs_e || (use_rt && idx == rt_e));
  endfunction

  function automatic logic [5:0] mdu_hold(input fsp_op_t op, input logic [31:0] a,
                                          input logic [31:0] b);
    logic [5:0] n;
    n = 6'd0;
    unique case (op)
      FSP_MULT, FSP_MULTU, FSP_MUL3: n = `FSP_MUL_HOLD;
      FSP_MULTIPLY_ADD_OP, FSP_MULTIPLY_SUBTRACT_OP:            n = `FSP_MAC_HOLD;
      FSP_DIVU:                      n = `FSP_DIV_HOLD;
      FSP_DIV: begin
        n = `FSP_DIV_HOLD;
        if (b[31]) begin
          n = `FSP_DIV_HOLD + `FSP_DIV_NEG_DIVSR;
        end else if (a[31]) begin
          n = `FSP_DIV_HOLD + `FSP_DIV_NEG_DIVND;
        end
      end
      default: n = 6'd0;
    endcase
    return n;
  endfunction

  // Decode and operand read in execute, two read ports with bypass
  assign op_e    = fsp_op_t'(st_q.e.ir[`FSP_OP_MSB:`FSP_OP_LSB]);
  assign rs_e    = st_q.e.ir[`FSP_RS_LSB +: 5];
  assign rt_e    = st_q.e.ir[`FSP_RT_LSB +: 5];
  assign rd_e    = st_q.e.ir[`FSP_RD_LSB +: 5];
  assign imm_e   = {{16{st_q.e.ir[15]}}, st_q.e.ir[15:0]};
  assign a_e     = fwd(rs_e);
  assign b_e     = fwd(rt_e);
  assign uses_rt = !(op_e inside {FSP_ADDI, FSP_LW, FSP_LBU, FSP_MFHI, FSP_MFLO});
  assign mdu_e   = op_e inside {FSP_MULT, FSP_MULTU, FSP_MULTIPLY_ADD_OP, FSP_MULTIPLY_SUBTRACT_OP, FSP_MUL3,
                                FSP_DIV, FSP_DIVU};

  always_comb begin
    unique case (op_e)
      FSP_ADD:                   alu_e = a_e + b_e;
      FSP_SUB:                   alu_e = a_e - b_e;
      FSP_AND:                   alu_e = a_e & b_e;
      FSP_OR:                    alu_e = a_e | b_e;
      FSP_ADDI, FSP_LW, FSP_LBU,
      FSP_SW:                    alu_e = a_e + imm_e;
      FSP_MFHI:                  alu_e = st_q.hi;
      FSP_MFLO:                  alu_e = st_q.lo;
      default:                   alu_e = 32'h0000_0000;
    endcase
  end

  // Branch resolves in execute; the word fetched behind it is a delay slot
  assign tgt_e   = st_q.e.pc + 32'h0000_0004 + {imm_e[29:0], 2'b00};
  assign br_take = st_q.e.valid && ((op_e == FSP_BEQ && a_e == b_e) ||
                                    (op_e == FSP_BNE && a_e != b_e));

  // Align stage value: load bytes shifted to bit 0
  always_comb begin
    logic [31:0] sh;
    sh    = st_q.a.res >> {st_q.a.bsel, 3'b000};
    a_val = st_q.a.lbu ? {24'h00_0000, sh[7:0]} : st_q.a.res;
  end

  // Multiply/divide result formed as the operation leaves the memory stage
  assign prod_s = $signed({{32{st_q.m.opa[31]}}, st_q.m.opa}) *
                  $signed({{32{st_q.m.opb[31]}}, st_q.m.opb});
  assign prod_u = {32'h0000_0000, st_q.m.opa} * {32'h0000_0000, st_q.m.opb};

  always_comb begin
    mdu_res = 64'h0000_0000_0000_0000;
    unique case (st_q.m.op)
      FSP_MULT, FSP_MUL3: mdu_res = prod_s;
      FSP_MULTU:          mdu_res = prod_u;
      FSP_MULTIPLY_ADD_OP:           mdu_res = {st_q.hi, st_q.lo} + prod_s;
      FSP_MULTIPLY_SUBTRACT_OP:           mdu_res = {st_q.hi, st_q.lo} - prod_s;
      FSP_DIV: begin
        if (st_q.m.opb != 32'h0000_0000) begin
          mdu_res = {32'($signed(st_q.m.opa) % $signed(st_q.m.opb)),
                     32'($signed(st_q.m.opa) / $signed(st_q.m.opb))};
        end
      end
      FSP_DIVU: begin
        if (st_q.m.opb != 32'h0000_0000) begin
          mdu_res = {st_q.m.opa % st_q.m.opb, st_q.m.opa / st_q.m.opb};
        end
      end
      default: mdu_res = 64'h0000_0000_0000_0000;
    endcase
  end

  // Stall terms
  assign hold_m   = st_q.m.valid && ((st_q.m.cnt != 6'd0) ||
                                     (st_q.m.mem && !dcache_ack_in));
  assign fetch_ok = st_q.ireq && icache_ack_in;
  // Load-use waits one cycle; high/low reads wait for a pending product
  assign hazard_e = st_q.e.valid && (
                    (st_q.m.valid && st_q.m.load && dep(st_q.m.rd, uses_rt)) ||
                    ((op_e inside {FSP_MFHI, FSP_MFLO}) &&
                     ((st_q.m.valid && st_q.m.multiply_divide_unit && st_q.m.op != FSP_MUL3) ||
                      (st_q.a.valid && st_q.a.multiply_divide_unit && st_q.a.op != FSP_MUL3))) ||
                    (st_q.m.valid && st_q.m.multiply_divide_unit && mdu_e) ||
                    (br_take && !fetch_ok));
  assign stall_e  = hold_m || hazard_e;

  always_comb begin
    st_d = st_q;

    // Writeback: register-file write port
    if (st_q.w.wen && st_q.w.rd != 5'd0) begin
      st_d.rf[st_q.w.rd] = st_q.w.res;
    end
    st_d.w.wen = st_q.a.valid && st_q.a.wen;
    st_d.w.rd  = st_q.a.rd;
    st_d.w.res = a_val;

    // Align: product registers updated here
    if (st_q.a.valid && st_q.a.multiply_divide_unit && st_q.a.op != FSP_MUL3) begin
      st_d.hi = st_q.a.prod[63:32];
      st_d.lo = st_q.a.prod[31:0];
    end

    // Memory to align
    if (hold_m) begin
      st_d.a.valid = 1'b0;
      st_d.a.multiply_divide_unit   = 1'b0;
      st_d.a.wen   = 1'b0;
    end else begin
      st_d.a.valid = st_q.m.valid;
      st_d.a.op    = st_q.m.op;
      st_d.a.rd    = st_q.m.rd;
      st_d.a.wen   = st_q.m.wen;
      st_d.a.multiply_divide_unit   = st_q.m.multiply_divide_unit;
      st_d.a.lbu   = st_q.m.load && st_q.m.op == FSP_LBU;
      st_d.a.bsel  = st_q.m.res[1:0];
      st_d.a.prod  = mdu_res;
      if (st_q.m.load) begin
        st_d.a.res = dcache_rdata_in;
      end else if (st_q.m.op == FSP_MUL3) begin
        st_d.a.res = mdu_res[31:0];
      end else begin
        st_d.a.res = st_q.m.res;
      end
    end

    // Execute to memory, or hold the memory stage
    if (hold_m) begin
      if (st_q.m.cnt != 6'd0) begin
        st_d.m.cnt = st_q.m.cnt - 6'd1;
      end
    end else if (stall_e) begin
      st_d.m       = '0;
    end else begin
      st_d.m.valid = st_q.e.valid;
      st_d.m.op    = op_e;
      st_d.m.load  = st_q.e.valid && (op_e inside {FSP_LW, FSP_LBU});
      st_d.m.store = st_q.e.valid && op_e == FSP_SW;
      st_d.m.mem   = st_q.e.valid && (op_e inside {FSP_LW, FSP_LBU, FSP_SW});
      st_d.m.multiply_divide_unit   = st_q.e.valid && mdu_e;
      st_d.m.cnt   = st_q.e.valid ? mdu_hold(op_e, a_e, b_e) - 6'd1 : 6'd0;
      if (st_d.m.cnt == 6'h3F) begin
        st_d.m.cnt = 6'd0;
      end
      st_d.m.wen   = st_q.e.valid &&
                     (op_e inside {FSP_ADD, FSP_SUB, FSP_AND, FSP_OR, FSP_ADDI, FSP_LW,
                                   FSP_LBU, FSP_MFHI, FSP_MFLO, FSP_MUL3});
      st_d.m.rd    = (op_e inside {FSP_ADDI, FSP_LW, FSP_LBU}) ? rt_e : rd_e;
      st_d.m.res   = alu_e;
      st_d.m.paddr = alu_e & `FSP_PHYS_MASK;
      st_d.m.opa   = a_e;
      st_d.m.opb   = b_e;
    end

    // Fetch into execute and next fetch address
    if (!stall_e) begin
      st_d.e.valid = fetch_ok;
      st_d.e.ir    = icache_data_in;
      st_d.e.pc    = st_q.pc;
      if (br_take) begin
        st_d.pc = tgt_e;
      end else if (fetch_ok) begin
        st_d.pc = st_q.pc + 32'h0000_0004;
      end
    end

    // Power-down: fetching stops, work already in flight drains
    if (st_q.pwr == FSP_SLEEP) begin
      if (wake_in) begin
        st_d.pwr  = FSP_RUN;
        st_d.ireq = 1'b1;
      end
    end else if (!stall_e && st_q.e.valid && op_e == FSP_WAIT) begin
      st_d.pwr  = FSP_SLEEP;
      st_d.ireq = 1'b0;
    end

    if (sys_rst_in) begin
      st_d      = '0;
      st_d.pc   = `FSP_RESET_PC;
      st_d.pwr  = FSP_RUN;
      st_d.ireq = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    st_q <= st_d;
  end

  assign icache_req_out   = st_q.ireq;
  assign icache_addr_out  = st_q.pc;
  assign dcache_req_out   = st_q.m.mem;
  assign dcache_we_out    = st_q.m.store;
  assign dcache_addr_out  = st_q.m.paddr;
  assign dcache_wdata_out = st_q.m.opb;
  assign sleep_out        = st_q.pwr == FSP_SLEEP;

endmodule

// file: test/fsp_pipe_sva.sv
// Port-level checks for the five-stage pipeline control.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module fsp_pipe_sva (
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        icache_ack_in,
  input wire logic        dcache_ack_in,
  input wire logic        wake_in,
  input wire logic        icache_req_out,
  input wire logic [31:0] icache_addr_out,
  input wire logic        dcache_req_out,
  input wire logic        dcache_we_out,
  input wire logic [31:0] dcache_addr_out,
  input wire logic [31:0] dcache_wdata_out,
  input wire logic        sleep_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  property p_rst_fetch;
    $fell(sys_rst_in) |-> icache_req_out && icache_addr_out == 32'h0 && !sleep_out;
  endproperty
  a_rst_fetch: assert property (p_rst_fetch) else $error("fetch side reset wrong");
  property p_rst_data;
    $fell(sys_rst_in) |-> !dcache_req_out && !dcache_we_out && dcache_addr_out == 32'h0;
  endproperty
  a_rst_data: assert property (p_rst_data) else $error("data side reset wrong");
  property p_dreq_hold;
    dcache_req_out && !dcache_ack_in |=> dcache_req_out && $stable(dcache_addr_out)
      && $stable(dcache_we_out) && $stable(dcache_wdata_out);
  endproperty
  a_dreq_hold: assert property (p_dreq_hold) else $error("data request dropped");
  property p_paddr;
    dcache_req_out |-> (dcache_addr_out & ~32'h1FFF_FFFF) == 32'h0;
  endproperty
  a_paddr: assert property (p_paddr) else $error("address not translated");
  property p_stall_freeze;
    dcache_req_out && !dcache_ack_in |=> $stable(icache_addr_out);
  endproperty
  a_stall_freeze: assert property (p_stall_freeze) else $error("fetch moved in stall");
  property p_sleep_nofetch;
    sleep_out |-> !icache_req_out;
  endproperty
  a_sleep_nofetch: assert property (p_sleep_nofetch) else $error("fetch while asleep");
  property p_wake;
    sleep_out && wake_in |=> !sleep_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_stay_asleep;
    sleep_out && !wake_in |=> sleep_out;
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep unasked");
  property p_fetch_align;
    icache_req_out |-> icache_addr_out[1:0] == 2'b00;
  endproperty
  a_fetch_align: assert property (p_fetch_align) else $error("fetch misaligned");
endmodule

bind fsp_pipe fsp_pipe_sva fsp_pipe_sva_i (
  .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .icache_ack_in(icache_ack_in),
  .dcache_ack_in(dcache_ack_in), .wake_in(wake_in), .icache_req_out(icache_req_out),
  .icache_addr_out(icache_addr_out), .dcache_req_out(dcache_req_out),
  .dcache_we_out(dcache_we_out), .dcache_addr_out(dcache_addr_out),
  .dcache_wdata_out(dcache_wdata_out), .sleep_out(sleep_out));

// file: test/fsp_cache_model.sv
// Cache pair model: instruction ROM with a test program and a data RAM.
// Assumes the pipeline holds each request, bar a fetch cut short by WAIT, until it samples an ack.
`timescale 1ns/1ps
module fsp_cache_model (
  input  wire logic        clk_sys_in,
  input  wire logic        icache_req_out,
  input  wire logic [31:0] icache_addr_out,
  input  wire logic        dcache_req_out,
  input  wire logic        dcache_we_out,
  input  wire logic [31:0] dcache_addr_out,
  input  wire logic [31:0] dcache_wdata_out,
  output logic [31:0]      icache_data_in,
  output logic             icache_ack_in,
  output logic [31:0]      dcache_rdata_in,
  output logic             dcache_ack_in
);
  function automatic logic [31:0] e(logic [5:0] o, logic [4:0] s, logic [4:0] t,
                                    logic [15:0] i);
    return {o, s, t, i};
  endfunction
  localparam logic [31:0] PROG [32] = '{
    e(5, 0, 1, 5), e(5, 0, 2, 7), e(1, 1, 2, 6144), e(8, 0, 3, 256),
    e(11, 1, 2, 0), e(19, 0, 0, 8192), e(8, 0, 4, 260), e(6, 0, 5, 256),
    e(1, 5, 5, 12288), e(8, 0, 6, 264), e(5, 0, 7, 16'hFFFD), e(16, 2, 7, 0),
    e(19, 0, 0, 16384), e(8, 0, 8, 268), e(18, 0, 0, 18432), e(8, 0, 9, 272),
    e(13, 1, 2, 0), e(19, 0, 0, 20480), e(8, 0, 10, 276), e(15, 1, 2, 22528),
    e(8, 0, 11, 280), e(9, 0, 0, 2), e(5, 0, 12, 1), e(5, 0, 12, 9),
    e(8, 0, 12, 284), e(7, 0, 13, 513), e(8, 0, 13, 288), e(20, 0, 0, 0),
    e(8, 0, 1, 292), e(8, 0, 2, 296), e(9, 0, 0, 16'hFFFF), 32'h0};
  logic [31:0] ram [256];
  initial begin
    icache_data_in = 32'h0;
    icache_ack_in = 1'b0;
    dcache_rdata_in = 32'h0;
    dcache_ack_in = 1'b0;
    foreach (ram[k]) ram[k] = 32'h0;
    ram[128] = 32'hA1B2C3D4;
  end
  always @(negedge clk_sys_in) begin
    if (dcache_req_out && dcache_we_out && dcache_ack_in) ram[dcache_addr_out[9:2]] = dcache_wdata_out;
  end
  // Lines not answering toggle, so a stale word never passes for a fresh one
  always @(posedge clk_sys_in) begin
    #1;
    icache_ack_in = icache_req_out && ($urandom_range(3) != 0);
    icache_data_in = icache_ack_in ? PROG[icache_addr_out[6:2]] : ~icache_data_in;
    dcache_ack_in = dcache_req_out && ($urandom_range(3) != 0);
    dcache_rdata_in = dcache_ack_in ? ram[dcache_addr_out[9:2]] : ~dcache_rdata_in;
  end
endmodule

// file: test/tb.sv
// Self-checking bench: runs a program and checks every store it makes.
// Assumes the cache model holds the program and answers with random delay.
`timescale 1ns/1ps
module tb;
  import fsp_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        wake_in = 1'b0;
  logic [31:0] icache_data_in, dcache_rdata_in, icache_addr_out, dcache_addr_out;
  logic [31:0] dcache_wdata_out;
  logic        icache_ack_in, dcache_ack_in, icache_req_out, dcache_req_out;
  logic        dcache_we_out, sleep_out;
  logic        woke = 1'b0;
  logic [31:0] ea_q [$];
  logic [31:0] ed_q [$];
  int          mismatches = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          t_prod = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;
  fsp_pipe fsp_pipe_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .icache_data_in(icache_data_in), .icache_ack_in(icache_ack_in),
    .dcache_rdata_in(dcache_rdata_in), .dcache_ack_in(dcache_ack_in), .wake_in(wake_in),
    .icache_req_out(icache_req_out), .icache_addr_out(icache_addr_out),
    .dcache_req_out(dcache_req_out), .dcache_we_out(dcache_we_out),
    .dcache_addr_out(dcache_addr_out), .dcache_wdata_out(dcache_wdata_out),
    .sleep_out(sleep_out));
  fsp_cache_model fsp_cache_model_i (.clk_sys_in(clk_sys_in),
    .icache_req_out(icache_req_out), .icache_addr_out(icache_addr_out),
    .dcache_req_out(dcache_req_out), .dcache_we_out(dcache_we_out),
    .dcache_addr_out(dcache_addr_out), .dcache_wdata_out(dcache_wdata_out),
    .icache_data_in(icache_data_in), .icache_ack_in(icache_ack_in),
    .dcache_rdata_in(dcache_rdata_in), .dcache_ack_in(dcache_ack_in));
  task automatic chk(input logic ok, input string m);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic cmp_store(input logic [31:0] a, input logic [31:0] d);
    if (ea_q.size() == 0) begin
      chk(1'b0, "unexpected store");
    end else begin
      chk(a === ea_q[0] && d === ed_q[0], "store address or data wrong");
      void'(ea_q.pop_front());
      void'(ed_q.pop_front());
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Stores are judged in the cycle the cache accepts them
  always @(negedge clk_sys_in) begin
    if (!sys_rst_in && dcache_req_out && dcache_we_out && dcache_ack_in) begin
      if (dcache_addr_out == 32'h0000_0100) t_prod = cyc;
      if (dcache_addr_out == 32'h0000_0104) chk(cyc - t_prod >= 32, "product early");
      if (dcache_addr_out == 32'h0000_0128) chk(woke, "store while asleep");
      cmp_store(dcache_addr_out, dcache_wdata_out);
    end
  end
  initial begin
    void'($urandom(9));
    ea_q = '{32'h100, 32'h104, 32'h108, 32'h10C, 32'h110, 32'h114, 32'h118, 32'h11C,
             32'h120, 32'h124, 32'h128};
    ed_q = '{32'h0000_000C, 32'h0000_0023, 32'h0000_0018, 32'hFFFF_FFFE, 32'h0000_0001,
             32'h0000_0021, 32'h0000_0023, 32'h0000_0001, 32'h0000_00C3, 32'h0000_0005,
             32'h0000_0007};
    repeat (3) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    for (int i = 0; i < 3000 && sleep_out !== 1'b1; i++) begin
      @(posedge clk_sys_in);
      #1;
    end
    chk(sleep_out === 1'b1, "no power-down");
    if (sleep_out !== 1'b1) begin
      final_report();
    end else begin
      repeat (5) @(posedge clk_sys_in);
      #1 woke = 1'b1;
      wake_in = 1'b1;
      @(posedge clk_sys_in);
      #1 wake_in = 1'b0;
      for (int i = 0; i < 3000 && ea_q.size() > 0; i++) @(posedge clk_sys_in);
      chk(ea_q.size() == 0, "stores missing");
      final_report();
    end
  end
endmodule
